/* logic/tmr_pkg.sv */
// Shared constants for the timer bypass block and its module-bus host.
// Function
// - Mode 111 keeps prescaler and counter off.
// - Bypass: running flag follows asserted gate while gate interrupt is disabled.
// - Bypass: gate negation sets event flag, interrupts.
// - Gate event flag clears only by one.
// - Bypass: gate level flag tracks gate pin.
// - Output pin updates only while release zero.
// - Output-control bits: 00 float, 01/10 zero, 11 one.
// - Bypass status: expiry, target, compare zero; prescaler FF.
// - Pin-level flag shows actual output pin level.
// - Reads finish without wait, 16 data bits.
// - Reserved location reads return zeros.
// - Writes without wait; read-only, reserved ignored.
// - Acknowledge: arbitrate, vector only when winning.
// - Vector resets to 0F; software programs it.
// - Module stop halts timer clocks until cleared.
// - Stopped: non-config accesses give bus error.
// - Debug halt select: 1x freezes, 0x ignores.
// - Privilege bit guards supervisor/user registers.
// - Arbitration priority zero stays out of acknowledge.
// - Request on line of programmed level.
// - Soft reset clears all but module config.
// - Interrupt, config registers supervisor only.
`default_nettype none
package tmr_pkg;
  // ****************************************************************
  // Module bus register map
  // ****************************************************************
  localparam logic [11:0] MCR_OFS    = 12'h600;
  localparam logic [11:0] IR_OFS     = 12'h604;
  localparam logic [11:0] CR_OFS     = 12'h606;
  localparam logic [11:0] SR_OFS     = 12'h608;
  localparam logic [15:0] MCR_RST    = 16'h0080;
  localparam logic [15:0] MCR_WMASK  = 16'hE08F;
  localparam logic [15:0] IR_RST     = 16'h000F;
  localparam logic [15:0] IR_WMASK   = 16'h07FF;
  localparam logic [15:0] CR_RST     = 16'h0000;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam int MCR_STP    = 15;
  localparam int MCR_FRZ_HI = 14;
  localparam int MCR_PRIVILEGE_SELECT   = 7;
  localparam int IARB_HI    = 3;
  localparam int IARB_LO    = 0;
  localparam int IL_HI      = 10;
  localparam int IL_LO      = 8;
  localparam int IV_HI      = 7;
  localparam int IV_LO      = 0;
  localparam int CR_SWR     = 15;
  localparam int CR_IE_TG   = 13;
  localparam int CR_TGE     = 11;
  localparam int CR_CPE     = 9;
  localparam int CR_MODE_HI = 4;
  localparam int CR_MODE_LO = 2;
  localparam int CR_OC_HI   = 1;
  localparam int CR_OC_LO   = 0;
  localparam int SR_IRQ     = 15;
  localparam int SR_TO      = 14;
  localparam int SR_TG      = 13;
  localparam int SR_TC      = 12;
  localparam int SR_TGL     = 11;
  localparam int SR_ON      = 10;
  localparam int SR_OUT     = 9;
  localparam int SR_COM     = 8;
  localparam int SR_PO_HI   = 7;
  localparam logic [2:0] MODE_BYPASS = 3'h7;
  localparam logic [1:0] OC_HIZ      = 2'h0;
  localparam logic [1:0] OC_ONE      = 2'h3;
  localparam logic [7:0] PO_BYPASS   = 8'hFF;
  localparam logic [3:0] IARB_NONE   = 4'h0;
  localparam logic [2:0] LEVEL_NONE  = 3'h0;
  localparam int NUM_LEVELS = 7;
  // ****************************************************************
  // Host Avalon register map (word addresses) and command codes
  // ****************************************************************
  localparam logic [2:0] AV_ADDR = 3'h0;
  localparam logic [2:0] AV_DATA = 3'h1;
  localparam logic [2:0] AV_GO   = 3'h2;
  localparam logic [2:0] AV_STAT = 3'h3;
  localparam logic [2:0] AV_IACK = 3'h4;
  localparam logic [2:0] AV_CTRL = 3'h5;
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_IACK  = 2'h2;
  localparam logic [1:0] CMD_SRST  = 2'h3;
  localparam int GO_SUPER = 2;
  localparam int DATA_BE_LO = 16;
endpackage
`default_nettype wire

/* logic/tmr_link_if.sv */
// Module bus between the timer device end and its host end.
`default_nettype none
interface tmr_link_if;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [1:0]  be;
  logic        rd;
  logic        wr;
  logic        supervisor;
  logic        iack;
  logic [2:0]  iack_level;
  logic [3:0]  arb_best;
  logic        soft_rst;
  logic        debug_halt;
  logic [15:0] rdata;
  logic        ack;
  logic        berr;
  logic [6:0]  irq_lines;
  logic        vec_valid;
  logic [7:0]  vector;
  logic        iack_done;
  modport dev (input addr, wdata, be, rd, wr, supervisor, iack, iack_level, arb_best,
               soft_rst, debug_halt,
               output rdata, ack, berr, irq_lines, vec_valid, vector, iack_done);
  modport host (output addr, wdata, be, rd, wr, supervisor, iack, iack_level, arb_best,
                soft_rst, debug_halt,
                input rdata, ack, berr, irq_lines, vec_valid, vector, iack_done);
endinterface
`default_nettype wire

/* logic/tmr_bypass_dev.sv */
// Timer device end: bypass I/O, module config, interrupt setup and bus slave.
//
// Added by the designer: the Avalon-MM register port.
`default_nettype none
module tmr_bypass_dev
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  resetn,
  // Module bus
  tmr_link_if.dev    bus,
  // Gate pin, active low
  input  wire logic  gate_input,
  // Timer output pin
  input  wire logic  timer_output_in,
  output logic       timer_output_out,
  output logic       timer_output_oe
);
  logic [15:0] mcr_ff;
  logic [15:0] ir_ff;
  logic [15:0] cr_ff;
  logic        gate_event_flag_ff;
  logic        running_ff;
  logic [2:0]  gate_sync_ff;
  logic        gate_lvl_ff;
  logic        gate_prev_ff;
  logic [2:0]  pin_sync_ff;
  logic        pin_lvl_ff;
  logic [15:0] rdata_ff;
  logic        ack_ff;
  logic        berr_ff;
  logic [6:0]  irq_ff;
  logic        vec_valid_ff;
  logic [7:0]  vector_ff;
  logic        iack_done_ff;
  logic        out_ff;
  logic        oe_ff;
  logic        run;
  logic        bypass;
  logic        access;
  logic        is_mcr;
  logic        is_ir;
  logic        is_cr;
  logic        is_sr;
  logic        denied;
  logic        reserved;
  logic [15:0] lane_mask;
  logic [15:0] status;
  logic        gate_neg;
  logic        irq_pending;
  logic        win;

  // ****************************************************************
  // Run control and decode
  // ****************************************************************
  // Stop or debug freeze
  assign run    = !mcr_ff[MCR_STP] && !(mcr_ff[MCR_FRZ_HI] && bus.debug_halt);
  assign bypass = (cr_ff[CR_MODE_HI:CR_MODE_LO] == MODE_BYPASS);
  assign access = bus.rd || bus.wr;
  assign is_mcr = (bus.addr == MCR_OFS);
  assign is_ir  = (bus.addr == IR_OFS);
  assign is_cr  = (bus.addr == CR_OFS);
  assign is_sr  = (bus.addr == SR_OFS);
  assign reserved = !(is_mcr || is_ir || is_cr || is_sr);
  assign denied = (mcr_ff[MCR_STP] && !is_mcr)
               || ((is_mcr || is_ir) && !bus.supervisor)
               || ((is_cr || is_sr) && mcr_ff[MCR_PRIVILEGE_SELECT] && !bus.supervisor);
  assign lane_mask = {{8{bus.be[1]}}, {8{bus.be[0]}}};
  assign gate_neg  = gate_lvl_ff && !gate_prev_ff;

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Bypass status fields
  always_comb begin
    status = ZERO16;
    status[SR_IRQ] = irq_pending;
    status[SR_TG]  = gate_event_flag_ff;
    status[SR_TGL] = gate_lvl_ff;
    status[SR_ON]  = running_ff;
    status[SR_OUT] = pin_lvl_ff;
    status[SR_PO_HI:0] = PO_BYPASS;
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Gate synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_sync_ff <= 3'h7;
      gate_lvl_ff  <= 1'b1;
    end else begin
      gate_sync_ff <= {gate_sync_ff[1:0], gate_input};
      if (gate_sync_ff[1] == gate_sync_ff[2]) begin
        gate_lvl_ff <= gate_sync_ff[2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync_ff <= 3'h0;
      pin_lvl_ff  <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], timer_output_in};
      if (pin_sync_ff[1] == pin_sync_ff[2]) begin
        pin_lvl_ff <= pin_sync_ff[2];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mcr_ff <= MCR_RST;
    end else if (bus.wr && is_mcr && !denied) begin
      mcr_ff <= (mcr_ff & ~(MCR_WMASK & lane_mask)) | (bus.wdata & MCR_WMASK & lane_mask);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ir_ff <= IR_RST;
      cr_ff <= CR_RST;
    end else if (bus.soft_rst) begin
      ir_ff <= IR_RST;
      cr_ff <= CR_RST;
    end else if (bus.wr && !denied) begin
      if (is_ir) begin
        ir_ff <= (ir_ff & ~(IR_WMASK & lane_mask)) | (bus.wdata & IR_WMASK & lane_mask);
      end
      if (is_cr) begin
        cr_ff <= (cr_ff & ~lane_mask) | (bus.wdata & lane_mask);
      end
    end
  end

  // ****************************************************************
  // Bypass gate behaviour
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_prev_ff <= 1'b1;
      running_ff   <= 1'b0;
    end else if (bus.soft_rst) begin
      gate_prev_ff <= gate_lvl_ff;
      running_ff   <= 1'b0;
    end else if (run) begin
      gate_prev_ff <= gate_lvl_ff;
      running_ff <= bypass && cr_ff[CR_CPE] && !cr_ff[CR_IE_TG] && !gate_lvl_ff;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_event_flag_ff <= 1'b0;
    end else if (bus.soft_rst) begin
      gate_event_flag_ff <= 1'b0;
    end else if (run && gate_neg && bypass && cr_ff[CR_IE_TG] && cr_ff[CR_TGE]
                 && cr_ff[CR_CPE]) begin
      gate_event_flag_ff <= 1'b1;
    end else if (bus.wr && is_sr && !denied && bus.be[1] && bus.wdata[SR_TG]) begin
      gate_event_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Timer output pin
  // ****************************************************************
  // Output driven from control bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (bus.soft_rst) begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (run && bypass && !cr_ff[CR_SWR]) begin
      oe_ff  <= (cr_ff[CR_OC_HI:CR_OC_LO] != OC_HIZ);
      out_ff <= (cr_ff[CR_OC_HI:CR_OC_LO] == OC_ONE);
    end
  end

  // ****************************************************************
  // Interrupt request and acknowledge
  // ****************************************************************
  assign irq_pending = gate_event_flag_ff && cr_ff[CR_IE_TG];
  assign win = bus.iack && irq_pending
            && (bus.iack_level == ir_ff[IL_HI:IL_LO])
            && (mcr_ff[IARB_HI:IARB_LO] != IARB_NONE)
            && (mcr_ff[IARB_HI:IARB_LO] > bus.arb_best);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 7'h00;
    end else begin
      for (int i = 0; i < NUM_LEVELS; i++) begin
        irq_ff[i] <= irq_pending && (ir_ff[IL_HI:IL_LO] != LEVEL_NONE)
                  && (ir_ff[IL_HI:IL_LO] == 3'(i + 1));
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      iack_done_ff <= 1'b0;
      vec_valid_ff <= 1'b0;
      vector_ff    <= 8'h00;
    end else begin
      iack_done_ff <= bus.iack;
      vec_valid_ff <= win;
      vector_ff    <= win ? ir_ff[IV_HI:IV_LO] : 8'h00;
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Zero-wait answer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff   <= 1'b0;
      berr_ff  <= 1'b0;
      rdata_ff <= ZERO16;
    end else begin
      ack_ff   <= access && !denied;
      berr_ff  <= access && denied;
      rdata_ff <= ZERO16;
      if (bus.rd && !denied && !reserved) begin
        if (is_mcr) begin
          rdata_ff <= mcr_ff;
        end else if (is_ir) begin
          rdata_ff <= ir_ff;
        end else if (is_cr) begin
          rdata_ff <= cr_ff;
        end else begin
          rdata_ff <= status;
        end
      end
    end
  end

  assign bus.rdata     = rdata_ff;
  assign bus.ack       = ack_ff;
  assign bus.berr      = berr_ff;
  assign bus.irq_lines = irq_ff;
  assign bus.vec_valid = vec_valid_ff;
  assign bus.vector    = vector_ff;
  assign bus.iack_done = iack_done_ff;
  assign timer_output_out = out_ff;
  assign timer_output_oe  = oe_ff;
endmodule
`default_nettype wire

/* logic/tmr_bus_host.sv */
// Host end: Avalon-MM command registers driving module bus cycles.
`default_nettype none
module tmr_bus_host
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Module bus
  tmr_link_if.host         bus
);
  typedef enum logic [1:0] {IDLE, ISSUE, WAIT} state_t;
  state_t      state_ff;
  logic [11:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [1:0]  be_ff;
  logic [1:0]  kind_ff;
  logic        super_ff;
  logic [2:0]  level_ff;
  logic [3:0]  best_ff;
  logic        halt_ff;
  logic        rd_ff;
  logic        wr_ff;
  logic        iack_ff;
  logic        srst_ff;
  logic        done_ff;
  logic        berr_ff;
  logic        won_ff;
  logic [15:0] result_ff;
  logic [7:0]  vector_ff;
  logic [31:0] readdata_ff;
  logic        wait_ff;
  logic        commit;
  logic        go;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Avalon slave: answer one cycle after the request
  // ****************************************************************
  assign commit = avs_write && !wait_ff;
  assign go     = commit && (avs_address == AV_GO) && (state_ff == IDLE);

  always_comb begin
    case (avs_address)
      AV_ADDR: rd_mux = {20'h00000, addr_ff};
      AV_DATA: rd_mux = {14'h0000, be_ff, wdata_ff};
      AV_STAT: rd_mux = {bus.irq_lines[3:0], won_ff, vector_ff, berr_ff, done_ff,
                         (state_ff != IDLE), result_ff};
      AV_IACK: rd_mux = {25'h0000000, best_ff, level_ff};
      AV_CTRL: rd_mux = {31'h00000000, halt_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff     <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff     <= 1'b0;
      readdata_ff <= rd_mux;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ff  <= 12'h000;
      wdata_ff <= 16'h0000;
      be_ff    <= 2'h3;
      kind_ff  <= CMD_READ;
      super_ff <= 1'b1;
      level_ff <= 3'h0;
      best_ff  <= 4'h0;
      halt_ff  <= 1'b0;
    end else if (commit) begin
      case (avs_address)
        AV_ADDR: addr_ff <= avs_writedata[11:0];
        AV_DATA: begin
          wdata_ff <= avs_writedata[15:0];
          be_ff    <= avs_writedata[DATA_BE_LO +: 2];
        end
        AV_GO: begin
          if (state_ff == IDLE) begin
            kind_ff  <= avs_writedata[1:0];
            super_ff <= avs_writedata[GO_SUPER];
          end
        end
        AV_IACK: begin
          level_ff <= avs_writedata[2:0];
          best_ff  <= avs_writedata[6:3];
        end
        AV_CTRL: halt_ff <= avs_writedata[0];
        default: halt_ff <= halt_ff;
      endcase
    end
  end

  // ****************************************************************
  // Module bus cycle sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= IDLE;
      rd_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      iack_ff  <= 1'b0;
      srst_ff  <= 1'b0;
    end else begin
      rd_ff   <= 1'b0;
      wr_ff   <= 1'b0;
      iack_ff <= 1'b0;
      srst_ff <= 1'b0;
      case (state_ff)
        IDLE: begin
          if (go) begin
            state_ff <= ISSUE;
          end
        end
        ISSUE: begin
          rd_ff    <= (kind_ff == CMD_READ);
          wr_ff    <= (kind_ff == CMD_WRITE);
          iack_ff  <= (kind_ff == CMD_IACK);
          srst_ff  <= (kind_ff == CMD_SRST);
          state_ff <= (kind_ff == CMD_SRST) ? IDLE : WAIT;
        end
        WAIT: begin
          if (bus.ack || bus.berr || bus.iack_done) begin
            state_ff <= IDLE;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_ff   <= 1'b0;
      berr_ff   <= 1'b0;
      won_ff    <= 1'b0;
      result_ff <= 16'h0000;
      vector_ff <= 8'h00;
    end else if (go) begin
      done_ff <= 1'b0;
      berr_ff <= 1'b0;
      won_ff  <= 1'b0;
    end else if (state_ff == WAIT && (bus.ack || bus.berr || bus.iack_done)) begin
      done_ff   <= 1'b1;
      berr_ff   <= bus.berr;
      won_ff    <= bus.vec_valid;
      result_ff <= bus.rdata;
      vector_ff <= bus.vec_valid ? bus.vector : IR_RST[7:0];
    end else if (state_ff == ISSUE && kind_ff == CMD_SRST) begin
      done_ff <= 1'b1;
    end
  end

  assign bus.addr       = addr_ff;
  assign bus.wdata      = wdata_ff;
  assign bus.be         = be_ff;
  assign bus.rd         = rd_ff;
  assign bus.wr         = wr_ff;
  assign bus.supervisor = super_ff;
  assign bus.iack       = iack_ff;
  assign bus.iack_level = level_ff;
  assign bus.arb_best   = best_ff;
  assign bus.soft_rst   = srst_ff;
  assign bus.debug_halt = halt_ff;
  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = wait_ff;
endmodule
`default_nettype wire

/* verification/tmr_link_assertions.sv */
// Checker of module-bus cycles between the timer end and the host end.
`default_nettype none
module tmr_link_assertions
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Module bus
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0]  be,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic        supervisor,
  input wire logic        iack,
  input wire logic [2:0]  iack_level,
  input wire logic        soft_rst,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        berr,
  input wire logic [6:0]  irq_lines,
  input wire logic        vec_valid,
  input wire logic [7:0]  vector,
  input wire logic        iack_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // Mirror of the configuration and interrupt setup registers
  // ****************************************************************
  logic        wq_ff;
  logic [11:0] aq_ff;
  logic [15:0] dq_ff;
  logic [1:0]  bq_ff;
  logic [15:0] mcr_ff;
  logic [15:0] ir_ff;
  logic [15:0] lane;
  logic        wok;
  assign lane = {{8{bq_ff[1]}}, {8{bq_ff[0]}}};
  assign wok = ack && wq_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wq_ff <= 1'b0;
    end else begin
      wq_ff <= wr;
    end
  end
  always_ff @(posedge core_clk) begin
    aq_ff <= addr;
    dq_ff <= wdata;
    bq_ff <= be;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mcr_ff <= MCR_RST;
    end else if (wok && aq_ff == MCR_OFS) begin
      mcr_ff <= (mcr_ff & ~(lane & MCR_WMASK)) | (dq_ff & lane & MCR_WMASK);
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ir_ff <= IR_RST;
    end else if (soft_rst) begin
      ir_ff <= IR_RST;
    end else if (wok && aq_ff == IR_OFS) begin
      ir_ff <= (ir_ff & ~(lane & IR_WMASK)) | (dq_ff & lane & IR_WMASK);
    end
  end
  AST_ANSWER: assert property ((rd || wr) |=> ack != berr)
    else $error("access not answered once in the next cycle");
  AST_QUIET: assert property (!(rd || wr) |=> !ack && !berr)
    else $error("answer without an access");
  AST_RESV: assert property (rd && addr == 12'h602 |=> rdata == ZERO16)
    else $error("reserved read returned nonzero data");
  AST_STOP: assert property ((rd || wr) && mcr_ff[MCR_STP] && addr != MCR_OFS |=> berr)
    else $error("stopped module answered without bus error");
  AST_SUPER: assert property ((rd || wr) && !supervisor && (addr == MCR_OFS || addr == IR_OFS)
    |=> berr)
    else $error("user access to supervisor register not refused");
  AST_PRIV: assert property ((rd || wr) && !supervisor && !mcr_ff[MCR_STP]
    && (addr == CR_OFS || addr == SR_OFS) |=> berr == $past(mcr_ff[MCR_PRIVILEGE_SELECT]))
    else $error("user access not governed by privilege select");
  AST_IACK: assert property (iack |=> iack_done)
    else $error("acknowledge cycle not completed");
  AST_WIN: assert property (vec_valid |-> iack_done && vector == ir_ff[IV_HI:IV_LO])
    else $error("vector differs from programmed vector");
  AST_IARB: assert property (iack && (mcr_ff[IARB_HI:IARB_LO] == IARB_NONE
    || iack_level != ir_ff[IL_HI:IL_LO]) |=> !vec_valid)
    else $error("vector supplied without arbitration right");
  AST_LINES: assert property ($onehot0(irq_lines))
    else $error("more than one request line active");
endmodule
`default_nettype wire

/* verification/test_timer_bypass_and_bus_config.sv */
// Testbench joining the timer end and the host end over the module bus.
`default_nettype none
module test_timer_bypass_and_bus_config;
  import tmr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus, checks and scenarios
  // ****************************************************************
  logic        core_clk;
  logic        resetn;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        gate_input;
  logic        tout_drv;
  logic        tout_oe;
  wire logic   tout_pin;
  logic [31:0] rq;
  logic        gv;
  logic [7:0]  vv;
  int          miscompares;
  int          checks_done;
  tmr_link_if link();
  // The board pulls the output pin high while nothing drives it.
  assign tout_pin = tout_oe ? tout_drv : 1'b1;
  tmr_bypass_dev tmr_bypass_dev_i (.core_clk, .resetn, .bus(link), .gate_input,
    .timer_output_in(tout_pin), .timer_output_out(tout_drv), .timer_output_oe(tout_oe));
  tmr_bus_host tmr_bus_host_i (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .bus(link));
  tmr_link_assertions tmr_link_assertions_i (.core_clk, .resetn, .addr(link.addr),
    .wdata(link.wdata), .be(link.be), .rd(link.rd), .wr(link.wr),
    .supervisor(link.supervisor), .iack(link.iack), .iack_level(link.iack_level),
    .soft_rst(link.soft_rst), .rdata(link.rdata), .ack(link.ack), .berr(link.berr),
    .irq_lines(link.irq_lines), .vec_valid(link.vec_valid), .vector(link.vector),
    .iack_done(link.iack_done));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (link.vec_valid === 1'b1) begin
      gv <= 1'b1;
      vv <= link.vector;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic mb(input logic [1:0] k, input logic s, input logic [11:0] a,
                    input logic [15:0] d);
    int n;
    av(1'b1, AV_ADDR, {20'h0, a});
    av(1'b1, AV_DATA, {14'h0, 2'h3, d});
    av(1'b1, AV_GO, {29'h0, s, k});
    n = 0;
    do begin
      av(1'b0, AV_STAT, 32'h0);
      n++;
    end while (rq[16] !== 1'b0 && n < 20);
    if (n >= 20) miscompares++;
  endtask
  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    mb(CMD_WRITE, 1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic s, input logic [15:0] e);
    mb(CMD_READ, s, a, ZERO16);
    chk({15'h0, rq[18], rq[15:0]}, {16'h0, e});
  endtask
  task automatic erc(input logic [11:0] a, input logic s);
    mb(CMD_READ, s, a, ZERO16);
    chk({31'h0, rq[18]}, 32'h1);
  endtask
  task automatic ia(input logic [2:0] l, input logic [3:0] b, input logic w,
                    input logic [7:0] v);
    av(1'b1, AV_IACK, {25'h0, b, l});
    gv = 1'b0;
    mb(CMD_IACK, 1'b1, 12'h000, ZERO16);
    chk({23'h0, gv, gv ? vv : 8'h00}, {23'h0, w, v});
  endtask
  task automatic t_regs();
    rdc(MCR_OFS, 1'b1, MCR_RST);
    rdc(IR_OFS, 1'b1, 16'h000F);
    wr16(12'h602, 16'hFFFF);
    rdc(12'h602, 1'b1, ZERO16);
    erc(MCR_OFS, 1'b0);
    erc(IR_OFS, 1'b0);
    erc(CR_OFS, 1'b0);
    wr16(MCR_OFS, 16'h0005);
    rdc(CR_OFS, 1'b0, CR_RST);
  endtask
  task automatic t_gate_in();
    wr16(CR_OFS, 16'h021C);
    gate_input <= 1'b0;
    rdc(SR_OFS, 1'b1, 16'h06FF);
    gate_input <= 1'b1;
    wr16(SR_OFS, 16'hFFFF);
    rdc(SR_OFS, 1'b1, 16'h0AFF);
  endtask
  task automatic t_irq();
    wr16(IR_OFS, 16'h0345);
    wr16(MCR_OFS, 16'h0085);
    wr16(CR_OFS, 16'h2A1C);
    gate_input <= 1'b0;
    rdc(SR_OFS, 1'b1, 16'h02FF);
    gate_input <= 1'b1;
    rdc(SR_OFS, 1'b1, 16'hAAFF);
    chk({25'h0, link.irq_lines}, 32'h4);
    ia(3'h3, 4'h4, 1'b1, 8'h45);
    ia(3'h3, 4'h6, 1'b0, 8'h00);
    ia(3'h2, 4'h0, 1'b0, 8'h00);
    wr16(MCR_OFS, 16'h0080);
    ia(3'h3, 4'h0, 1'b0, 8'h00);
    wr16(MCR_OFS, 16'h0085);
    wr16(SR_OFS, 16'h0000);
    rdc(SR_OFS, 1'b1, 16'hAAFF);
    wr16(SR_OFS, 16'h2000);
    rdc(SR_OFS, 1'b1, 16'h0AFF);
    chk({25'h0, link.irq_lines}, 32'h0);
  endtask
  task automatic t_out();
    for (int i = 0; i < 4; i++) begin
      wr16(CR_OFS, 16'h021C | 16'(i));
      chk({30'h0, tout_oe, tout_drv}, {30'h0, i != 0, i == 3});
      rdc(SR_OFS, 1'b1, (i == 0 || i == 3) ? 16'h0AFF : 16'h08FF);
    end
    wr16(CR_OFS, 16'h821E);
    chk({30'h0, tout_oe, tout_drv}, 32'h3);
  endtask
  task automatic t_stop();
    mb(CMD_SRST, 1'b1, 12'h000, ZERO16);
    rdc(IR_OFS, 1'b1, IR_RST);
    rdc(MCR_OFS, 1'b1, 16'h0085);
    rdc(CR_OFS, 1'b1, CR_RST);
    chk({31'h0, tout_oe}, 32'h0);
    wr16(MCR_OFS, 16'h8085);
    erc(CR_OFS, 1'b1);
    erc(IR_OFS, 1'b1);
    rdc(MCR_OFS, 1'b1, 16'h8085);
    wr16(MCR_OFS, 16'h0085);
    rdc(IR_OFS, 1'b1, IR_RST);
    wr16(CR_OFS, 16'h021E);
    av(1'b1, AV_CTRL, 32'h1);
    wr16(MCR_OFS, 16'h6085);
    wr16(CR_OFS, 16'h021F);
    chk({31'h0, tout_drv}, 32'h0);
    wr16(MCR_OFS, 16'h2085);
    wr16(CR_OFS, 16'h021F);
    chk({31'h0, tout_drv}, 32'h1);
    av(1'b1, AV_CTRL, 32'h0);
  endtask
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    gate_input = 1'b1;
    gv = 1'b0;
    vv = 8'h00;
    miscompares = 0;
    checks_done = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_gate_in();
    t_irq();
    t_out();
    t_stop();
    final_report();
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
